// >>> sfw_core_model.sv
// behavioural model of the internal command logic on the core port
`timescale 1ns/100ps
module sfw_core_model
  import sfw_pkg::*;
(
  input wire logic mclk,
  output sfw_core_req_t core_req,
  input wire logic [7:0] core_rd_data,
  input wire logic core_rd_valid
);
  //////////////////////////////////////////////////////////////////////////////
  // idle data lines show the inverse of the last byte so nothing stale looks valid
  initial core_req = '0;

  // back-to-back pushes, one byte per cycle, counting up from start
  task automatic push_bytes(input int n, input logic [7:0] start);
    for (int i = 0; i < n; i++) begin
      @(posedge mclk);
      core_req <= '{wr_en: 1'b1, rd_en: 1'b0, wr_data: start + i[7:0]};
    end
    @(posedge mclk);
    core_req <= '{wr_en: 1'b0, rd_en: 1'b0, wr_data: ~core_req.wr_data};
  endtask : push_bytes

  // single pop; the byte shows in the cycle after the pop edge
  task automatic pop_byte(output logic [7:0] data, output logic valid);
    @(posedge mclk);
    core_req <= '{wr_en: 1'b0, rd_en: 1'b1, wr_data: ~core_req.wr_data};
    @(posedge mclk);
    core_req <= '{wr_en: 1'b0, rd_en: 1'b0, wr_data: ~core_req.wr_data};
    #1;
    data = core_rd_data;
    valid = core_rd_valid;
  endtask : pop_byte
endmodule : sfw_core_model

// >>> sfw_level.sv
// capacity selection and watermark comparison of the fill count
`timescale 1ns/100ps
`include "sfw_regs.svh"
module sfw_level #(
  parameter int CW = 10,
  parameter int DEPTH = 512
) (
  input wire logic [CW-1:0] count,
  input wire logic small_cap,
  input wire logic [8:0] thr,
  output logic [CW-1:0] cap,
  output logic full,
  output logic empty,
  output logic near_full,
  output logic near_empty
);

  localparam logic [CW-1:0] CAP_FULL = CW'(DEPTH);

  ////////////////////////////////////////////////////////////////
  // >= keeps full honest when the capacity shrinks under a fuller buffer
  always_comb begin
    cap = small_cap ? `SFW_CAP_SMALL : CAP_FULL;
    full = (count >= cap);
    empty = (count == '0);
    near_full = ((cap - count) <= CW'(thr)) || full;
    near_empty = (count <= CW'(thr));
  end

endmodule : sfw_level

// >>> sfw_mem.sv
// byte-wide storage array with one write and one registered read port
`timescale 1ns/100ps
module sfw_mem #(
  parameter int DEPTH = 512,
  parameter int AW = 9
) (
  input wire logic mclk,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [7:0] rd_data
);

  logic [7:0] mem [DEPTH];

  ////////////////////////////////////////////////////////////////
  // no reset on the array, a data read of the emptied buffer still returns a stale byte
  always_ff @(posedge mclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule : sfw_mem

// >>> sfw_pkg.sv
// types shared by the shared buffer modules
package sfw_pkg;

  localparam int SFW_PTR_W = 9;
  localparam int SFW_CNT_W = 10;

  typedef enum logic [1:0] {
    SFW_RD_IDLE = 2'b00,
    SFW_RD_FETCH = 2'b01,
    SFW_RD_RESP = 2'b10
  } sfw_rd_state_t;

  // request from the internal command state machine
  typedef struct packed {
    logic wr_en;
    logic rd_en;
    logic [7:0] wr_data;
  } sfw_core_req_t;

  // every flip-flop of the top module
  typedef struct packed {
    logic [SFW_PTR_W-1:0] wr_ptr;
    logic [SFW_PTR_W-1:0] rd_ptr;
    logic [SFW_CNT_W-1:0] count;
    logic small_cap;
    logic [8:0] thr;
    logic ovfl;
    logic [2:0] evt_stat;
    logic [2:0] evt_en;
    logic ne_prev;
    logic nf_prev;
    logic aw_held;
    logic [31:0] aw_addr;
    logic w_held;
    logic [7:0] w_data;
    logic w_strb0;
    logic bvalid;
    logic [1:0] bresp;
    sfw_rd_state_t rd_st;
    logic [31:0] ar_addr;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic core_rd_valid;
  } sfw_state_t;

endpackage : sfw_pkg

// >>> sfw_regs.svh
// register indices, field positions and reset values of the shared buffer
`ifndef SFW_REGS_SVH
`define SFW_REGS_SVH
// register indices; byte address is four times the index
`define SFW_IDX_CTRL 8'h02
`define SFW_IDX_THR_LO 8'h03
`define SFW_IDX_LEVEL 8'h04
`define SFW_IDX_DATA 8'h05
`define SFW_IDX_EVT_STAT 8'h06
`define SFW_IDX_EVT_EN 8'h07
// buffer control register fields
`define SFW_CTRL_LEVEL_HI 0
`define SFW_CTRL_SMALL 1
`define SFW_CTRL_THR_HI 2
`define SFW_CTRL_OVFL 3
`define SFW_CTRL_NEAR_EMPTY 4
`define SFW_CTRL_NEAR_FULL 5
`define SFW_CTRL_CLEAR 7
// event status and enable fields
`define SFW_EVT_ERROR 0
`define SFW_EVT_NEAR_EMPTY 1
`define SFW_EVT_NEAR_FULL 2
// capacities and reset values
`define SFW_CAP_SMALL 10'h0ff
`define SFW_THR_RESET 9'h000
`define SFW_EVT_RESET 3'h0
`define SFW_RESP_OKAY 2'b00
`define SFW_RESP_SLVERR 2'b10
`endif

// >>> sfw_top.sv
// shared byte buffer with watermark alerts behind an AXI4-Lite slave
//
// How it works
// - one 512-entry byte buffer carries data both ways between host and core.
// - capacity may be cut to 255 bytes; threshold then fits in one byte.
// - capacity select bit at 1 gives 255 bytes, otherwise full capacity.
// - the core may read or write the buffer while its command runs.
// - writing 1 to the clear bit zeroes pointers and fill count.
// - each write adds one, each read takes one; count high bit in control.
// - threshold is control bit 2 above the low threshold byte.
// - near-full is set while capacity minus count is at most the threshold.
// - near-empty is set while the count is at most the threshold.
// - a write into a full buffer sets overflow and the error event bit.
// - with its enable set, near-empty rising raises the interrupt pin.
// - with its enable set, near-full rising raises the interrupt pin.
`timescale 1ns/100ps
`include "sfw_regs.svh"
module sfw_top
  import sfw_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire sfw_core_req_t core_req,
  output logic [7:0] core_rd_data,
  output logic core_rd_valid,
  output logic core_full,
  output logic core_empty,
  output logic irq
);

  localparam int DEPTH = 1 << SFW_PTR_W;

  sfw_state_t s_reg;
  sfw_state_t s_next;
  logic [SFW_CNT_W-1:0] cap;
  logic full;
  logic empty;
  logic near_full;
  logic near_empty;
  logic [7:0] mem_rd_data;
  logic aw_fire;
  logic w_fire;
  logic ar_fire;
  logic wr_go;
  logic [7:0] widx;
  logic wr_byte;
  logic host_push;
  logic host_pop;
  logic push_req;
  logic pop_req;
  logic do_push;
  logic do_pop;
  logic clear;
  logic ovfl_evt;
  logic [7:0] push_data;
  logic [2:0] evt_set;
  logic [2:0] evt_clr;
  logic [7:0] rd_byte;

  ////////////////////////////////////////////////////////////////
  // address decoding, shared by the read and write paths

  function automatic logic [7:0] sfw_index(input logic [31:0] addr);
    sfw_index = addr[9:2];
  endfunction : sfw_index

  function automatic logic sfw_mapped(input logic [31:0] addr);
    sfw_mapped = (addr[31:10] == '0) && (addr[9:2] >= `SFW_IDX_CTRL) && (addr[9:2] <= `SFW_IDX_EVT_EN);
  endfunction : sfw_mapped

  ////////////////////////////////////////////////////////////////
  // storage and watermark compare

  sfw_mem #(
    .DEPTH(DEPTH),
    .AW(SFW_PTR_W)
  ) u_mem (
    .mclk(mclk),
    .wr_en(do_push),
    .wr_addr(s_reg.wr_ptr),
    .wr_data(push_data),
    .rd_addr(s_reg.rd_ptr),
    .rd_data(mem_rd_data)
  );

  sfw_level #(
    .CW(SFW_CNT_W),
    .DEPTH(DEPTH)
  ) u_level (
    .count(s_reg.count),
    .small_cap(s_reg.small_cap),
    .thr(s_reg.thr),
    .cap(cap),
    .full(full),
    .empty(empty),
    .near_full(near_full),
    .near_empty(near_empty)
  );

  ////////////////////////////////////////////////////////////////
  // bus handshakes and the decoded requests of this cycle
  always_comb begin
    s_axi_awready = !s_reg.aw_held && !s_reg.bvalid;
    s_axi_wready = !s_reg.w_held && !s_reg.bvalid;
    s_axi_arready = (s_reg.rd_st == SFW_RD_IDLE);
    aw_fire = s_axi_awvalid && s_axi_awready;
    w_fire = s_axi_wvalid && s_axi_wready;
    ar_fire = s_axi_arvalid && s_axi_arready;
    // the write takes effect once address and data are both held
    wr_go = s_reg.aw_held && s_reg.w_held;
    widx = sfw_index(s_reg.aw_addr);
    wr_byte = wr_go && s_reg.w_strb0 && sfw_mapped(s_reg.aw_addr);
    host_push = wr_byte && (widx == `SFW_IDX_DATA);
    host_pop = ar_fire && sfw_mapped(s_axi_araddr) && (sfw_index(s_axi_araddr) == `SFW_IDX_DATA);
    // core wins a clash; keeping clear of running commands is the host's duty
    push_req = core_req.wr_en || host_push;
    pop_req = core_req.rd_en || host_pop;
    push_data = core_req.wr_en ? core_req.wr_data : s_reg.w_data;
    clear = wr_byte && (widx == `SFW_IDX_CTRL) && s_reg.w_data[`SFW_CTRL_CLEAR];
    do_push = push_req && !full && !clear;
    do_pop = pop_req && !empty && !clear;
    ovfl_evt = push_req && full;
    // alert events are the rising edges of the flags
    evt_set = '0;
    evt_set[`SFW_EVT_ERROR] = ovfl_evt;
    evt_set[`SFW_EVT_NEAR_EMPTY] = near_empty && !s_reg.ne_prev;
    evt_set[`SFW_EVT_NEAR_FULL] = near_full && !s_reg.nf_prev;
    evt_clr = (wr_byte && (widx == `SFW_IDX_EVT_STAT)) ? s_reg.w_data[2:0] : 3'h0;
  end

  ////////////////////////////////////////////////////////////////
  // read mux, sampled into the response register one cycle after acceptance
  always_comb begin
    rd_byte = 8'h00;
    case (sfw_index(s_reg.ar_addr))
      `SFW_IDX_CTRL: begin
        rd_byte[`SFW_CTRL_LEVEL_HI] = s_reg.count[8];
        rd_byte[`SFW_CTRL_SMALL] = s_reg.small_cap;
        rd_byte[`SFW_CTRL_THR_HI] = s_reg.thr[8];
        rd_byte[`SFW_CTRL_OVFL] = s_reg.ovfl;
        rd_byte[`SFW_CTRL_NEAR_EMPTY] = near_empty;
        rd_byte[`SFW_CTRL_NEAR_FULL] = near_full;
      end
      `SFW_IDX_THR_LO: begin
        rd_byte = s_reg.thr[7:0];
      end
      `SFW_IDX_LEVEL: begin
        rd_byte = s_reg.count[7:0];
      end
      `SFW_IDX_DATA: begin
        rd_byte = mem_rd_data;
      end
      `SFW_IDX_EVT_STAT: begin
        rd_byte = {5'h00, s_reg.evt_stat};
      end
      `SFW_IDX_EVT_EN: begin
        rd_byte = {5'h00, s_reg.evt_en};
      end
      default: begin
        rd_byte = 8'h00;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////
  // next state of the whole block
  always_comb begin
    s_next = s_reg;
    // buffer pointers and fill count
    if (clear) begin
      s_next.wr_ptr = '0;
      s_next.rd_ptr = '0;
      s_next.count = '0;
    end else begin
      if (do_push) begin
        s_next.wr_ptr = s_reg.wr_ptr + 1'b1;
      end
      if (do_pop) begin
        s_next.rd_ptr = s_reg.rd_ptr + 1'b1;
      end
      s_next.count = s_reg.count + SFW_CNT_W'(do_push) - SFW_CNT_W'(do_pop);
    end
    // overflow stays until the next clear; a new overflow wins over it
    s_next.ovfl = ovfl_evt || (s_reg.ovfl && !clear);
    // software written configuration
    if (wr_byte && (widx == `SFW_IDX_CTRL)) begin
      s_next.small_cap = s_reg.w_data[`SFW_CTRL_SMALL];
      s_next.thr[8] = s_reg.w_data[`SFW_CTRL_THR_HI];
    end
    if (wr_byte && (widx == `SFW_IDX_THR_LO)) begin
      s_next.thr[7:0] = s_reg.w_data;
    end
    if (wr_byte && (widx == `SFW_IDX_EVT_EN)) begin
      s_next.evt_en = s_reg.w_data[2:0];
    end
    // sticky events, set beats a write-one clear
    s_next.evt_stat = evt_set | (s_reg.evt_stat & ~evt_clr);
    s_next.ne_prev = near_empty;
    s_next.nf_prev = near_full;
    // write channel capture, either order
    if (aw_fire) begin
      s_next.aw_held = 1'b1;
      s_next.aw_addr = s_axi_awaddr;
    end
    if (w_fire) begin
      s_next.w_held = 1'b1;
      s_next.w_data = s_axi_wdata[7:0];
      s_next.w_strb0 = s_axi_wstrb[0];
    end
    if (wr_go) begin
      s_next.aw_held = 1'b0;
      s_next.w_held = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = sfw_mapped(s_reg.aw_addr) ? `SFW_RESP_OKAY : `SFW_RESP_SLVERR;
    end else if (s_reg.bvalid && s_axi_bready) begin
      s_next.bvalid = 1'b0;
    end
    // read channel; fetch waits one cycle for the array output
    case (s_reg.rd_st)
      SFW_RD_IDLE: begin
        if (ar_fire) begin
          s_next.ar_addr = s_axi_araddr;
          s_next.rd_st = SFW_RD_FETCH;
        end
      end
      SFW_RD_FETCH: begin
        s_next.rdata = {24'h000000, rd_byte};
        s_next.rresp = sfw_mapped(s_reg.ar_addr) ? `SFW_RESP_OKAY : `SFW_RESP_SLVERR;
        s_next.rd_st = SFW_RD_RESP;
      end
      SFW_RD_RESP: begin
        if (s_axi_rready) begin
          s_next.rd_st = SFW_RD_IDLE;
        end
      end
      default: begin
        s_next.rd_st = SFW_RD_IDLE;
      end
    endcase
    s_next.core_rd_valid = core_req.rd_en && !empty && !clear;
  end

  ////////////////////////////////////////////////////////////////
  // state register; near-empty starts high so reset raises no event
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s_reg <= '0;
      s_reg.thr <= `SFW_THR_RESET;
      s_reg.evt_stat <= `SFW_EVT_RESET;
      s_reg.evt_en <= `SFW_EVT_RESET;
      s_reg.ne_prev <= 1'b1;
      s_reg.rd_st <= SFW_RD_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  ////////////////////////////////////////////////////////////////
  // outputs
  always_comb begin
    s_axi_bvalid = s_reg.bvalid;
    s_axi_bresp = s_reg.bresp;
    s_axi_rvalid = (s_reg.rd_st == SFW_RD_RESP);
    s_axi_rdata = s_reg.rdata;
    s_axi_rresp = s_reg.rresp;
    core_rd_data = mem_rd_data;
    core_rd_valid = s_reg.core_rd_valid;
    core_full = full;
    core_empty = empty;
    irq = |(s_reg.evt_stat & s_reg.evt_en);
  end

  ////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge mclk);
  endclocking

  default disable iff (sys_rst);

  AST_CAP_BOUND: assert property (s_reg.count <= SFW_CNT_W'(DEPTH))
    else $error("fill count above buffer depth");

  AST_SMALL_OVFL: assert property (
    (s_reg.small_cap && s_reg.count == `SFW_CAP_SMALL && push_req && !pop_req && !clear)
    |=> (s_reg.count == `SFW_CAP_SMALL) && s_reg.evt_stat[`SFW_EVT_ERROR])
    else $error("reduced capacity not enforced at 255 bytes");

  AST_CORE_READ: assert property ((core_req.rd_en && !empty && !clear) |=> core_rd_valid)
    else $error("core read not answered next cycle");

  AST_CLEAR: assert property (clear |=> (s_reg.count == '0) && (s_reg.wr_ptr == s_reg.rd_ptr) && near_empty)
    else $error("clear did not empty the buffer");

  AST_PUSH_INC: assert property ((do_push && !do_pop) |=> s_reg.count == $past(s_reg.count) + 1'b1)
    else $error("write did not raise the fill count by one");

  AST_POP_DEC: assert property ((do_pop && !do_push) |=> s_reg.count == $past(s_reg.count) - 1'b1)
    else $error("read did not lower the fill count by one");

  AST_THR_LOW: assert property ((wr_byte && widx == `SFW_IDX_THR_LO) |=> s_reg.thr[7:0] == $past(s_reg.w_data))
    else $error("threshold low byte not taken");

  AST_NEAR_FULL_AT_FULL: assert property ((s_reg.count == cap) |-> near_full)
    else $error("near-full clear while buffer full");

  AST_NEAR_EMPTY_RANGE: assert property ((s_reg.count <= SFW_CNT_W'(s_reg.thr)) |-> near_empty)
    else $error("near-empty clear at or below threshold");

  AST_OVFL: assert property (ovfl_evt |=> s_reg.ovfl && s_reg.evt_stat[`SFW_EVT_ERROR])
    else $error("overflow not flagged");

  AST_NE_IRQ: assert property (
    (near_empty && !s_reg.ne_prev && s_reg.evt_en[`SFW_EVT_NEAR_EMPTY]) |=> irq)
    else $error("near-empty rise did not raise the interrupt");

  AST_NF_IRQ: assert property (
    (near_full && !s_reg.nf_prev && s_reg.evt_en[`SFW_EVT_NEAR_FULL]) |=> irq)
    else $error("near-full rise did not raise the interrupt");

  AST_FULL_WRITE: assert property (
    (push_req && full && !pop_req && !clear) |=> s_reg.count == $past(s_reg.count))
    else $error("write into full buffer changed the count");

  AST_EMPTY_READ: assert property ((pop_req && empty && !push_req) |=> s_reg.count == '0)
    else $error("read from empty buffer changed the count");

  COV_OVERFLOW: cover property (ovfl_evt);
  COV_CLEAR_FULL: cover property (full ##[1:20] clear);
  COV_HOST_POP: cover property (host_pop ##2 s_axi_rvalid);
  COV_IRQ: cover property ($rose(irq));

endmodule : sfw_top

// >>> sfw_top_tb.sv
// self-checking bench of the shared buffer: axi4-lite host tasks plus core model
`timescale 1ns/100ps
`include "sfw_regs.svh"
module sfw_top_tb
  import sfw_pkg::*;
;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
  logic [3:0] wstrb = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, core_rd_valid, core_full, core_empty, irq;
  logic [1:0] bresp, rresp;
  logic [7:0] core_rd_data, pop_d;
  logic pop_v;
  logic [31:0] rd_d;
  logic [1:0] rd_r;
  sfw_core_req_t core_req;
  int error_cnt = 0, checked = 0, cycles = 0;

  always #4 mclk = ~mclk;

  sfw_top u_dut (.mclk(mclk), .sys_rst(sys_rst), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .core_req(core_req), .core_rd_data(core_rd_data),
    .core_rd_valid(core_rd_valid), .core_full(core_full), .core_empty(core_empty), .irq(irq));

  sfw_core_model u_core (.mclk(mclk), .core_req(core_req), .core_rd_data(core_rd_data),
    .core_rd_valid(core_rd_valid));

  //////////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    if (error_cnt == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : test_done

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // hang guard, well above the fewer than one thousand cycles the sequence needs
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      test_done();
    end
  end

  function automatic logic [31:0] ra(input logic [7:0] idx);
    return {22'h0, idx, 2'b00};
  endfunction : ra

  //////////////////////////////////////////////////////////////////////////////
  // handshakes are judged mid-cycle, where every signal has settled
  task automatic axi_write(input logic [31:0] addr, input logic [7:0] data, output logic [1:0] resp);
    logic done, a_hs, w_hs;
    done = 1'b0;
    @(posedge mclk);
    awaddr <= addr;
    wdata <= {24'h0, data};
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done) begin
      @(negedge mclk);
      a_hs = awvalid && awready;
      w_hs = wvalid && wready;
      done = bvalid;
      resp = bresp;
      @(posedge mclk);
      if (a_hs) awvalid <= 1'b0;
      if (w_hs) wvalid <= 1'b0;
      if (done) bready <= 1'b0;
    end
  endtask : axi_write

  task automatic axi_read(input logic [31:0] addr, output logic [31:0] data, output logic [1:0] resp);
    logic done, a_hs;
    done = 1'b0;
    @(posedge mclk);
    araddr <= addr;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done) begin
      @(negedge mclk);
      a_hs = arvalid && arready;
      done = rvalid;
      data = rdata;
      resp = rresp;
      @(posedge mclk);
      if (a_hs) arvalid <= 1'b0;
      if (done) rready <= 1'b0;
    end
  endtask : axi_read

  task automatic reg_wr(input logic [31:0] addr, input logic [7:0] data, input logic [1:0] exp);
    logic [1:0] r;
    axi_write(addr, data, r);
    check("bresp", {30'h0, r}, {30'h0, exp});
  endtask : reg_wr

  task automatic reg_chk(input string name, input logic [31:0] addr, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    axi_read(addr, d, r);
    check({name, " rresp"}, {30'h0, r}, {30'h0, `SFW_RESP_OKAY});
    check(name, d, exp);
  endtask : reg_chk

  task automatic pin_chk(input string name, input logic seen_now, input logic exp);
    check(name, {31'h0, seen_now}, {31'h0, exp});
  endtask : pin_chk

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge mclk);
    // reset state, unmapped places
    reg_chk("ctrl", ra(`SFW_IDX_CTRL), 32'h10);
    reg_chk("thr_lo", ra(`SFW_IDX_THR_LO), 32'h00);
    reg_chk("evt_stat", ra(`SFW_IDX_EVT_STAT), 32'h00);
    axi_read(32'h40, rd_d, rd_r);
    check("unmapped rresp", {30'h0, rd_r}, {30'h0, `SFW_RESP_SLVERR});
    check("unmapped rdata", rd_d, 32'h0);
    reg_wr(32'h44, 8'h55, `SFW_RESP_SLVERR);
    // host fills, core drains: near-empty rise raises the pin
    reg_wr(ra(`SFW_IDX_THR_LO), 8'h02, `SFW_RESP_OKAY);
    reg_wr(ra(`SFW_IDX_EVT_EN), 8'h07, `SFW_RESP_OKAY);
    for (int i = 1; i <= 3; i++) reg_wr(ra(`SFW_IDX_DATA), 8'ha0 + i[7:0], `SFW_RESP_OKAY);
    reg_chk("level", ra(`SFW_IDX_LEVEL), 32'h03);
    reg_chk("ctrl", ra(`SFW_IDX_CTRL), 32'h00);
    u_core.pop_byte(pop_d, pop_v);
    pin_chk("core_rd_valid", pop_v, 1'b1);
    check("core_rd_data", {24'h0, pop_d}, 32'ha1);
    reg_chk("evt_stat", ra(`SFW_IDX_EVT_STAT), 32'h02);
    @(negedge mclk);
    pin_chk("irq", irq, 1'b1);
    reg_wr(ra(`SFW_IDX_EVT_STAT), 8'h02, `SFW_RESP_OKAY);
    @(negedge mclk);
    pin_chk("irq", irq, 1'b0);
    reg_chk("data", ra(`SFW_IDX_DATA), 32'ha2);
    // small capacity up to overflow; near-full masked; host stays off while core works
    reg_wr(ra(`SFW_IDX_EVT_EN), 8'h01, `SFW_RESP_OKAY);
    reg_wr(ra(`SFW_IDX_CTRL), 8'h82, `SFW_RESP_OKAY);
    reg_chk("level", ra(`SFW_IDX_LEVEL), 32'h00);
    @(negedge mclk);
    pin_chk("core_empty", core_empty, 1'b1);
    u_core.pop_byte(pop_d, pop_v);
    pin_chk("core_rd_valid", pop_v, 1'b0);
    reg_chk("level", ra(`SFW_IDX_LEVEL), 32'h00);
    u_core.push_bytes(254, 8'h00);
    reg_chk("evt_stat", ra(`SFW_IDX_EVT_STAT), 32'h04);
    @(negedge mclk);
    pin_chk("irq", irq, 1'b0);
    u_core.push_bytes(1, 8'hfe);
    @(negedge mclk);
    pin_chk("core_full", core_full, 1'b1);
    u_core.push_bytes(1, 8'hee);
    reg_chk("level", ra(`SFW_IDX_LEVEL), 32'hff);
    reg_chk("ctrl", ra(`SFW_IDX_CTRL), 32'h2a);
    reg_chk("evt_stat", ra(`SFW_IDX_EVT_STAT), 32'h05);
    @(negedge mclk);
    pin_chk("irq", irq, 1'b1);
    reg_chk("data", ra(`SFW_IDX_DATA), 32'h00);
    reg_wr(ra(`SFW_IDX_EVT_STAT), 8'h05, `SFW_RESP_OKAY);
    reg_wr(ra(`SFW_IDX_CTRL), 8'h80, `SFW_RESP_OKAY);
    reg_chk("ctrl", ra(`SFW_IDX_CTRL), 32'h10);
    // full capacity, nine-bit threshold 258, near-full at its exact boundary
    reg_wr(ra(`SFW_IDX_EVT_EN), 8'h05, `SFW_RESP_OKAY);
    reg_wr(ra(`SFW_IDX_CTRL), 8'h04, `SFW_RESP_OKAY);
    u_core.push_bytes(253, 8'h00);
    reg_chk("ctrl", ra(`SFW_IDX_CTRL), 32'h14);
    u_core.push_bytes(1, 8'hfd);
    reg_chk("ctrl", ra(`SFW_IDX_CTRL), 32'h34);
    reg_chk("evt_stat", ra(`SFW_IDX_EVT_STAT), 32'h06);
    @(negedge mclk);
    pin_chk("irq", irq, 1'b1);
    u_core.push_bytes(46, 8'hfe);
    reg_chk("ctrl", ra(`SFW_IDX_CTRL), 32'h25);
    reg_chk("level", ra(`SFW_IDX_LEVEL), 32'h2c);
    reg_chk("data", ra(`SFW_IDX_DATA), 32'h00);
    test_done();
  end
endmodule : sfw_top_tb
